// ==== spr_access_privilege_check.v ====
// Notes on behaviour
// R1 - User class reads and writes anywhere; user read-only reads anywhere, never written.
// R2 - Guest-supervisor class allowed whenever user mode is off; read-only variant only reads.
// R3 - Hypervisor classes only with guest and user bits both zero; variant limits direction.
// R4 - Read/clear register write clears bits set in operand, keeps the others.
// R5 - Unimplemented register number raises illegal-operation regardless of mode bits.
// R6 - Read of write-only or write of read-only raises illegal-operation.
// R7 - Implemented privileged register touched in user mode raises privilege-operation.
// R8 - User mode on unimplemented privileged number gives illegal-operation, not privilege.
// R9 - Hypervisor register touched in guest supervisor state raises hypervisor privilege.
// R10 - Class names least privilege; more privileged states are also allowed.
// R11 - Numbers 526 and 527 read alternate time base halves, user level, never written.
// R12 - Number 304 is read/clear debug status; 306 writes the same debug status.
// R13 - Numbers 576 and 975 are user readable and writable.
// R14 - On any exception, target register and destination operand stay unchanged.
`timescale 1ns/10ps

module spr_access_privilege_check #(
    parameter DATA_W = 32
) (
    input  wire              ref_clk,
    input  wire              rst,
    input  wire              move_valid,
    input  wire              move_is_write,
    input  wire [9:0]        special_reg_number,
    input  wire [DATA_W-1:0] general_operand_reg,
    input  wire              user_mode_bit,
    input  wire              guest_state_bit,
    input  wire [63:0]       alt_timebase,
    input  wire [DATA_W-1:0] debug_status_set,
    output reg               move_done,
    output reg  [DATA_W-1:0] read_data,
    output reg               read_data_valid,
    output reg               illegal_op_exc,
    output reg               privilege_op_exc,
    output reg               hyp_privilege_exc,
    output wire [DATA_W-1:0] debug_status,
    output wire [DATA_W-1:0] embedded_cpu_control,
    output wire [DATA_W-1:0] debug_control_0,
    output wire [DATA_W-1:0] branch_unit_ctrl_status
);

`include "spr_check_defines.vh"

    localparam NUM_SLOTS = `NUM_SLOTS;
    localparam DBG_SLOT  = 5'h06;

    wire [7:0] reg_class;
    wire [4:0] reg_slot;

    reg  [DATA_W-1:0] slot_q [0:NUM_SLOTS-1];

    reg  can_read;
    reg  can_write;
    reg  implemented;
    reg  allowed;
    reg  is_hyp_class;
    reg  illegal_d;
    reg  priv_d;
    reg  hyp_d;
    wire is_dbg_clear;
    wire commit_write;
    reg  [DATA_W-1:0] rd_value;

    spr_class_decode u_decode (
        .special_reg_number (special_reg_number),
        .reg_class          (reg_class),
        .reg_slot           (reg_slot)
    );

    // Direction and privilege screening; hypervisor state passes every lower class
    always @* begin
        implemented  = (reg_class != `CLS_NONE);
        can_read     = 1'b0;
        can_write    = 1'b0;
        allowed      = 1'b0;
        is_hyp_class = 1'b0;
        case (reg_class)
            `CLS_USER: begin                                      // see R1 see R13
                can_read  = 1'b1;
                can_write = 1'b1;
                allowed   = 1'b1;
            end
            `CLS_USER_RO: begin                                   // see R1 see R11
                can_read  = 1'b1;
                allowed   = 1'b1;
            end
            `CLS_GSUP: begin
                can_read  = 1'b1;
                can_write = 1'b1;
                allowed   = ~user_mode_bit;                       // see R2 see R10
            end
            `CLS_GSUP_RO: begin
                can_read  = 1'b1;
                allowed   = ~user_mode_bit;                       // see R2
            end
            `CLS_HYP, `CLS_HYP_RCLR: begin
                can_read     = 1'b1;
                can_write    = 1'b1;
                is_hyp_class = 1'b1;
                allowed      = ~user_mode_bit & ~guest_state_bit; // see R3
            end
            `CLS_HYP_RO: begin
                can_read     = 1'b1;
                is_hyp_class = 1'b1;
                allowed      = ~user_mode_bit & ~guest_state_bit; // see R3
            end
            `CLS_HYP_WO: begin
                can_write    = 1'b1;
                is_hyp_class = 1'b1;
                allowed      = ~user_mode_bit & ~guest_state_bit; // see R3
            end
            default: begin
                allowed = 1'b0;
            end
        endcase
    end

    // Exception priority: illegal first, then user privilege, then guest hypervisor
    always @* begin
        illegal_d = 1'b0;
        priv_d    = 1'b0;
        hyp_d     = 1'b0;
        if (!implemented) begin
            illegal_d = 1'b1;                                     // see R5 see R8
        end else if (move_is_write ? !can_write : !can_read) begin
            illegal_d = 1'b1;                                     // see R6
        end else if (!allowed && user_mode_bit) begin
            priv_d = 1'b1;                                        // see R7
        end else if (!allowed && is_hyp_class) begin
            hyp_d = 1'b1;                                         // see R9
        end
    end

    assign is_dbg_clear = (reg_class == `CLS_HYP_RCLR);
    assign commit_write = move_valid & move_is_write & ~illegal_d & ~priv_d & ~hyp_d;

    // Read mux; time base halves come straight from the running counter
    always @* begin
        rd_value = {DATA_W{1'b0}};
        if (special_reg_number == `SPECIAL_REG_NUMBER_ATB_LOWER)
            rd_value = alt_timebase[31:0];                        // see R11
        else if (special_reg_number == `SPECIAL_REG_NUMBER_ATB_UPPER)
            rd_value = alt_timebase[63:32];                       // see R11
        else if (reg_slot != `SLOT_NONE)
            rd_value = slot_q[reg_slot];
    end

    // Storage slots; debug status also collects hardware events, set beats clear
    genvar gi;
    generate
        for (gi = 0; gi < NUM_SLOTS; gi = gi + 1) begin : g_slot
            always @(posedge ref_clk or posedge rst) begin
                if (rst) begin
                    slot_q[gi] <= `SPR_RESET_VAL;
                end else if (gi == DBG_SLOT) begin
                    if (commit_write && reg_slot == gi && is_dbg_clear)
                        slot_q[gi] <= (slot_q[gi] & ~general_operand_reg)
                                      | debug_status_set;          // see R4 see R12
                    else if (commit_write && reg_slot == gi)
                        slot_q[gi] <= general_operand_reg | debug_status_set; // see R12
                    else
                        slot_q[gi] <= slot_q[gi] | debug_status_set;
                end else if (commit_write && reg_slot == gi) begin
                    slot_q[gi] <= general_operand_reg;            // see R14
                end
            end
        end
    endgenerate

    // One-cycle answer; a refused move neither completes nor returns data
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            move_done         <= 1'b0;
            read_data         <= {DATA_W{1'b0}};
            read_data_valid   <= 1'b0;
            illegal_op_exc    <= 1'b0;
            privilege_op_exc  <= 1'b0;
            hyp_privilege_exc <= 1'b0;
        end else begin
            move_done         <= move_valid & ~illegal_d & ~priv_d & ~hyp_d; // see R14
            illegal_op_exc    <= move_valid & illegal_d;
            privilege_op_exc  <= move_valid & priv_d;
            hyp_privilege_exc <= move_valid & hyp_d;
            read_data_valid   <= move_valid & ~move_is_write & ~illegal_d & ~priv_d & ~hyp_d;
            if (move_valid && !move_is_write && !illegal_d && !priv_d && !hyp_d)
                read_data <= rd_value;                            // see R14
        end
    end

    // Register contents that steer other core logic
    assign debug_status            = slot_q[DBG_SLOT];
    assign embedded_cpu_control    = slot_q[5'h07];
    assign debug_control_0         = slot_q[5'h08];
    assign branch_unit_ctrl_status = slot_q[5'h14];

endmodule // spr_access_privilege_check

// ==== spr_check_defines.vh ====
`ifndef SPR_CHECK_DEFINES_VH
`define SPR_CHECK_DEFINES_VH

// Register numbers (10-bit special register number space)
`define SPECIAL_REG_NUMBER_COUNT          10'h009
`define SPECIAL_REG_NUMBER_DOWN_CNT       10'h016
`define SPECIAL_REG_NUMBER_DOWN_RELOAD    10'h036
`define SPECIAL_REG_NUMBER_CRIT_SR0       10'h03a
`define SPECIAL_REG_NUMBER_CRIT_SR1       10'h03b
`define SPECIAL_REG_NUMBER_DATA_FAULT     10'h03d
`define SPECIAL_REG_NUMBER_DBG_STATUS     10'h130
`define SPECIAL_REG_NUMBER_DBG_STATUS_WR  10'h132
`define SPECIAL_REG_NUMBER_CPU_CTRL       10'h133
`define SPECIAL_REG_NUMBER_DBG_CTRL0      10'h134
`define SPECIAL_REG_NUMBER_DBG_CTRL1      10'h135
`define SPECIAL_REG_NUMBER_DBG_CTRL2      10'h136
`define SPECIAL_REG_NUMBER_DADDR_CMP1     10'h13c
`define SPECIAL_REG_NUMBER_DADDR_CMP2     10'h13d
`define SPECIAL_REG_NUMBER_ATB_LOWER      10'h20e
`define SPECIAL_REG_NUMBER_ATB_UPPER      10'h20f
`define SPECIAL_REG_NUMBER_DBG_CTRL4      10'h233
`define SPECIAL_REG_NUMBER_DBG_SR0        10'h23e
`define SPECIAL_REG_NUMBER_DBG_SR1        10'h23f
`define SPECIAL_REG_NUMBER_DBG_ACQ        10'h240
`define SPECIAL_REG_NUMBER_CORE_DEV_CS    10'h2b8
`define SPECIAL_REG_NUMBER_EPID_LOAD      10'h3b3
`define SPECIAL_REG_NUMBER_DBG_EVENT      10'h3cf
`define SPECIAL_REG_NUMBER_BRANCH_CS      10'h3f5

// Access classes, one-hot; CLS_NONE is all zero
`define CLS_NONE            8'h00
`define CLS_USER            8'h01
`define CLS_USER_RO         8'h02
`define CLS_GSUP            8'h04
`define CLS_GSUP_RO         8'h08
`define CLS_HYP             8'h10
`define CLS_HYP_RO          8'h20
`define CLS_HYP_WO          8'h40
`define CLS_HYP_RCLR        8'h80

// Storage slot indices
`define SLOT_W              5
`define NUM_SLOTS           22
`define SLOT_NONE           5'h1f

// Reset values of stored registers
`define SPR_RESET_VAL       32'h0000_0000

`endif

// ==== spr_class_decode.v ====
`timescale 1ns/10ps

// Maps a register number to its access class and storage slot
module spr_class_decode (
    input  wire [9:0] special_reg_number,
    output reg  [7:0] reg_class,
    output reg  [4:0] reg_slot
);

`include "spr_check_defines.vh"

    // Pure lookup; unlisted numbers fall to the no-class default
    always @* begin
        reg_class = `CLS_NONE;
        reg_slot  = `SLOT_NONE;
        case (special_reg_number)
            `SPECIAL_REG_NUMBER_COUNT:         begin reg_class = `CLS_USER;     reg_slot = 5'h00; end
            `SPECIAL_REG_NUMBER_DOWN_CNT:      begin reg_class = `CLS_HYP;      reg_slot = 5'h01; end
            `SPECIAL_REG_NUMBER_DOWN_RELOAD:   begin reg_class = `CLS_HYP;      reg_slot = 5'h02; end
            `SPECIAL_REG_NUMBER_CRIT_SR0:      begin reg_class = `CLS_HYP;      reg_slot = 5'h03; end
            `SPECIAL_REG_NUMBER_CRIT_SR1:      begin reg_class = `CLS_HYP;      reg_slot = 5'h04; end
            `SPECIAL_REG_NUMBER_DATA_FAULT:    begin reg_class = `CLS_GSUP;     reg_slot = 5'h05; end
            `SPECIAL_REG_NUMBER_DBG_STATUS:    begin reg_class = `CLS_HYP_RCLR; reg_slot = 5'h06; end
            `SPECIAL_REG_NUMBER_DBG_STATUS_WR: begin reg_class = `CLS_HYP;      reg_slot = 5'h06; end
            `SPECIAL_REG_NUMBER_CPU_CTRL:      begin reg_class = `CLS_HYP;      reg_slot = 5'h07; end
            `SPECIAL_REG_NUMBER_DBG_CTRL0:     begin reg_class = `CLS_HYP;      reg_slot = 5'h08; end
            `SPECIAL_REG_NUMBER_DBG_CTRL1:     begin reg_class = `CLS_HYP;      reg_slot = 5'h09; end
            `SPECIAL_REG_NUMBER_DBG_CTRL2:     begin reg_class = `CLS_HYP;      reg_slot = 5'h0a; end
            `SPECIAL_REG_NUMBER_DADDR_CMP1:    begin reg_class = `CLS_HYP;      reg_slot = 5'h0b; end
            `SPECIAL_REG_NUMBER_DADDR_CMP2:    begin reg_class = `CLS_HYP;      reg_slot = 5'h0c; end
            `SPECIAL_REG_NUMBER_ATB_LOWER:     begin reg_class = `CLS_USER_RO;  reg_slot = `SLOT_NONE; end
            `SPECIAL_REG_NUMBER_ATB_UPPER:     begin reg_class = `CLS_USER_RO;  reg_slot = `SLOT_NONE; end
            `SPECIAL_REG_NUMBER_DBG_CTRL4:     begin reg_class = `CLS_HYP;      reg_slot = 5'h0d; end
            `SPECIAL_REG_NUMBER_DBG_SR0:       begin reg_class = `CLS_HYP;      reg_slot = 5'h0e; end
            `SPECIAL_REG_NUMBER_DBG_SR1:       begin reg_class = `CLS_HYP;      reg_slot = 5'h0f; end
            `SPECIAL_REG_NUMBER_DBG_ACQ:       begin reg_class = `CLS_USER;     reg_slot = 5'h10; end
            `SPECIAL_REG_NUMBER_CORE_DEV_CS:   begin reg_class = `CLS_HYP;      reg_slot = 5'h11; end
            `SPECIAL_REG_NUMBER_EPID_LOAD:     begin reg_class = `CLS_GSUP;     reg_slot = 5'h12; end
            `SPECIAL_REG_NUMBER_DBG_EVENT:     begin reg_class = `CLS_USER;     reg_slot = 5'h13; end
            `SPECIAL_REG_NUMBER_BRANCH_CS:     begin reg_class = `CLS_HYP;      reg_slot = 5'h14; end
            default:             begin reg_class = `CLS_NONE;     reg_slot = `SLOT_NONE; end
        endcase
    end

endmodule // spr_class_decode

// ==== spr_access_privilege_check_props.sv ====
`timescale 1ns/10ps
// Move answers land one cycle after the taking edge
module spr_access_privilege_check_props #(
    parameter DATA_W = 32
) (
    input wire              ref_clk,
    input wire              rst,
    input wire              move_valid,
    input wire              move_is_write,
    input wire [9:0]        special_reg_number,
    input wire              user_mode_bit,
    input wire              guest_state_bit,
    input wire [63:0]       alt_timebase,
    input wire              move_done,
    input wire [DATA_W-1:0] read_data,
    input wire              read_data_valid,
    input wire              illegal_op_exc,
    input wire              privilege_op_exc,
    input wire              hyp_privilege_exc
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // Short aliases keep each property on a line or two
    wire [3:0] ans = {move_done, illegal_op_exc, privilege_op_exc, hyp_privilege_exc};
    wire [9:0] n   = special_reg_number;
    wire       v   = move_valid;
    wire       pr  = user_mode_bit;

    one_answer_a: assert property (v |=> $onehot(ans))
        else $error("move not answered by one outcome");
    idle_quiet_a: assert property (!v |=> ans == 4'h0)
        else $error("outcome without a move");
    unimpl_num_a: assert property (v && n == 10'h000 |=> illegal_op_exc)
        else $error("unimplemented number not illegal");
    ro_write_a: assert property (v && move_is_write && n[9:1] == 9'h107
        |=> illegal_op_exc)
        else $error("time base write not illegal");
    user_class_a: assert property (v && n == 10'h009 |=> move_done)
        else $error("user class move refused");
    user_priv_a: assert property (v && pr && n == 10'h134 |=> privilege_op_exc)
        else $error("user access to privileged not refused");
    guest_hyp_a: assert property (v && !pr && guest_state_bit && n == 10'h134
        |=> hyp_privilege_exc)
        else $error("guest access to hypervisor not refused");
    gsup_open_a: assert property (v && !pr && n == 10'h03d |=> move_done)
        else $error("guest supervisor access refused");
    read_hold_a: assert property (!read_data_valid |-> $stable(read_data))
        else $error("read data moved without a read");
    tb_low_a: assert property (v && !move_is_write && n == 10'h20e
        |=> read_data == $past(alt_timebase[31:0]))
        else $error("time base low word wrong");
endmodule // spr_access_privilege_check_props

bind spr_access_privilege_check spr_access_privilege_check_props #(.DATA_W(DATA_W)) i_props (
    .ref_clk(ref_clk), .rst(rst), .move_valid(move_valid), .move_is_write(move_is_write),
    .special_reg_number(special_reg_number), .user_mode_bit(user_mode_bit),
    .guest_state_bit(guest_state_bit), .alt_timebase(alt_timebase), .move_done(move_done),
    .read_data(read_data), .read_data_valid(read_data_valid), .illegal_op_exc(illegal_op_exc),
    .privilege_op_exc(privilege_op_exc), .hyp_privilege_exc(hyp_privilege_exc));

// ==== core_move_issuer.sv ====
`timescale 1ns/10ps
// Pipeline stand-in: presents one register move at a time
module core_move_issuer (
    input  wire        ref_clk,
    output reg         move_valid,
    output reg         move_is_write,
    output reg  [9:0]  special_reg_number,
    output reg  [31:0] general_operand_reg,
    output reg         user_mode_bit,
    output reg         guest_state_bit,
    output reg  [63:0] alt_timebase,
    output reg  [31:0] debug_status_set
);
    // Time base frozen so reads are predictable; event bits raised only by pulse_set
    initial begin
        move_valid = 1'b0;
        move_is_write = 1'b0;
        special_reg_number = 10'h000;
        general_operand_reg = 32'h0000_0000;
        user_mode_bit = 1'b0;
        guest_state_bit = 1'b0;
        alt_timebase = 64'h0123_4567_89ab_cdef;
        debug_status_set = 32'h0000_0000;
    end
    // Drive after an edge, hold through the taking edge, then release
    task issue(input logic we, input logic [9:0] num, input logic pr, input logic gs,
               input logic [31:0] op);
        @(posedge ref_clk);
        move_valid <= 1'b1;
        move_is_write <= we;
        special_reg_number <= num;
        general_operand_reg <= op;
        user_mode_bit <= pr;
        guest_state_bit <= gs;
        @(posedge ref_clk);
        move_valid <= 1'b0;
        general_operand_reg <= ~op; // Stale operand must not leak into state
        #1;
    endtask
    // Event bits for one cycle; started beside issue, they meet the same taking edge
    task pulse_set(input logic [31:0] bits);
        @(posedge ref_clk);
        debug_status_set <= bits;
        @(posedge ref_clk);
        debug_status_set <= 32'h0000_0000;
        #1;
    endtask
endmodule // core_move_issuer

// ==== test_spr_access_privilege_check.sv ====
`timescale 1ns/10ps
module test_spr_access_privilege_check;
    reg          ref_clk = 1'b0;
    reg          rst = 1'b1;
    integer      err_count = 0;
    integer      checks = 0;
    integer      cyc = 0;
    integer      i;
    wire         mv, we, pr, gs, done, rdv, ill, prv, hyp;
    wire [9:0]   num;
    wire [31:0]  op, hw_set, rd, dbg_st, dbg_c0, cpu_ctl, br_cs;
    wire [63:0]  tb;
    logic [2:0]  got;
    logic [15:0] tbl [0:16];

    core_move_issuer i_core (.ref_clk(ref_clk), .move_valid(mv), .move_is_write(we),
        .special_reg_number(num), .general_operand_reg(op), .user_mode_bit(pr),
        .guest_state_bit(gs), .alt_timebase(tb), .debug_status_set(hw_set));
    spr_access_privilege_check i_dut (.ref_clk(ref_clk), .rst(rst), .move_valid(mv),
        .move_is_write(we), .special_reg_number(num), .general_operand_reg(op),
        .user_mode_bit(pr), .guest_state_bit(gs), .alt_timebase(tb), .debug_status_set(hw_set),
        .move_done(done), .read_data(rd), .read_data_valid(rdv), .illegal_op_exc(ill),
        .privilege_op_exc(prv), .hyp_privilege_exc(hyp), .debug_status(dbg_st),
        .embedded_cpu_control(cpu_ctl), .debug_control_0(dbg_c0),
        .branch_unit_ctrl_status(br_cs));

    // Outcome code: 0 done, 1 illegal, 2 privilege, 3 hypervisor, 7 none
    assign got = hyp ? 3'd3 : prv ? 3'd2 : ill ? 3'd1 : done ? 3'd0 : 3'd7;
    always #5 ref_clk = ~ref_clk;
    // Hang guard: the run needs well under 300 cycles
    always @(posedge ref_clk) begin
        cyc = cyc + 1;
        if (cyc == 2000) begin
            err_count = err_count + 1;
            close_out();
        end
    end

    task close_out;
        $display("Counts: %0d checks, %0d mismatches", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks = checks + 1;
        if (g !== e) begin
            err_count = err_count + 1;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task mv_chk(input logic w, input logic [9:0] n, input logic p, input logic g,
                input logic [31:0] d, input logic [2:0] e);
        i_core.issue(w, n, p, g, d);
        chk("outcome", {29'h0, e}, {29'h0, got});
        chk("read_data_valid", {31'h0, !w && e == 3'd0}, {31'h0, rdv});
    endtask

    initial begin
        // Packed as {write, user, guest, 0, outcome[1:0], number[9:0]}
        tbl = '{16'he009, 16'h4009, 16'h620e, 16'h860f, 16'ha03d, 16'h483d, 16'h8134,
                16'had34, 16'h4934, 16'h0400, 16'he420, 16'h47ff, 16'h2d30, 16'hc240,
                16'h63cf, 16'h8132, 16'h0240};
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        for (i = 0; i < 17; i = i + 1) begin
            mv_chk(tbl[i][15], tbl[i][9:0], tbl[i][14], tbl[i][13], 32'ha5a5_0000,
                   tbl[i][12:10]);
        end
        $display("Access class table done");
        mv_chk(1'b1, 10'h134, 1'b0, 1'b0, 32'h1357_9bdf, 3'd0);
        chk("debug_control_0", 32'h1357_9bdf, dbg_c0);
        mv_chk(1'b1, 10'h134, 1'b1, 1'b0, 32'hffff_ffff, 3'd2);
        chk("debug_control_0", 32'h1357_9bdf, dbg_c0);
        mv_chk(1'b0, 10'h134, 1'b0, 1'b0, 32'h0, 3'd0);
        chk("read_data", 32'h1357_9bdf, rd);
        mv_chk(1'b0, 10'h134, 1'b0, 1'b1, 32'h0, 3'd3);
        chk("read_data", 32'h1357_9bdf, rd);
        mv_chk(1'b1, 10'h132, 1'b0, 1'b0, 32'hf0f0_00ff, 3'd0);
        chk("debug_status", 32'hf0f0_00ff, dbg_st);
        mv_chk(1'b1, 10'h130, 1'b0, 1'b0, 32'h3030_000f, 3'd0);
        chk("debug_status", 32'hc0c0_00f0, dbg_st);
        mv_chk(1'b0, 10'h130, 1'b0, 1'b0, 32'h0, 3'd0);
        chk("read_data", 32'hc0c0_00f0, rd);
        // Event and clear in one cycle: the event bit must survive the clear
        fork
            i_core.issue(1'b1, 10'h130, 1'b0, 1'b0, 32'hc000_0000);
            i_core.pulse_set(32'h8000_0001);
        join
        chk("debug_status", 32'h80c0_00f1, dbg_st);
        mv_chk(1'b1, 10'h133, 1'b0, 1'b0, 32'h0bad_f00d, 3'd0);
        chk("embedded_cpu_control", 32'h0bad_f00d, cpu_ctl);
        mv_chk(1'b1, 10'h3f5, 1'b0, 1'b1, 32'h2468_ace0, 3'd3);
        chk("branch_unit_ctrl_status", 32'h0000_0000, br_cs);
        mv_chk(1'b0, 10'h20e, 1'b1, 1'b0, 32'h0, 3'd0);
        chk("read_data", 32'h89ab_cdef, rd);
        mv_chk(1'b0, 10'h20f, 1'b1, 1'b1, 32'h0, 3'd0);
        chk("read_data", 32'h0123_4567, rd);
        $display("Register data tests done");
        close_out();
    end
endmodule // test_spr_access_privilege_check
